// File: pmicis_regs.vh
/*
 * register offsets, bit positions, reset values and timing constants for the
 * latched interrupt status block. assumes a 200 MHz register clock.
 */
`ifndef PMICIS_REGS_VH
`define PMICIS_REGS_VH

// register offsets on the serial register port
`define PMICIS_ADDR_RESET 8'h18
`define PMICIS_ADDR_TOP1 8'h19
`define PMICIS_ADDR_TOP2 8'h1A
`define PMICIS_ADDR_BUCK 8'h1B
`define PMICIS_ADDR_LINREG 8'h1C
`define PMICIS_ADDR_STAT 8'h1D

// top interrupt register one
`define PMICIS_T1_PG_LOST 7
`define PMICIS_T1_LINREG 6
`define PMICIS_T1_BUCK 5
`define PMICIS_T1_SYNC 4
`define PMICIS_T1_TSD 3
`define PMICIS_T1_TWARN 2
`define PMICIS_T1_OVP 1
`define PMICIS_T1_MEAS 0
// latched (write-one-clear) bits of top register one; 6 and 5 are summaries
`define PMICIS_T1_W1C_MASK 8'h9F

// top interrupt register two
`define PMICIS_T2_RST 0
`define PMICIS_T2_W1C_MASK 8'h01

// buck and linear-regulator flag layouts, second unit upper nibble
`define PMICIS_U_PG_B 6
`define PMICIS_U_SC_B 5
`define PMICIS_U_ILIM_B 4
`define PMICIS_U_PG_A 2
`define PMICIS_U_SC_A 1
`define PMICIS_U_ILIM_A 0
`define PMICIS_U_W1C_MASK 8'h77

// software reset bit in the reset register
`define PMICIS_RST_SW 0

// live status register bit positions
`define PMICIS_ST_PG 7
`define PMICIS_ST_SYNC 4
`define PMICIS_ST_TSD 3
`define PMICIS_ST_TWARN 2
`define PMICIS_ST_OVP 1

`define PMICIS_FLAGS_RESET 8'h00

// short-circuit qualification time: 1 ms of 200 MHz cycles, sized to the counter
`define PMICIS_SC_CYCLES 18'd200000
`define PMICIS_SC_CNT_W 18

// synchronised pin vector layout
// current-limit levels have a synchroniser of their own and are not in here
`define PMICIS_SYN_W 14
`define PMICIS_P_PG 0
`define PMICIS_P_SYNC 1
`define PMICIS_P_TSD 2
`define PMICIS_P_TWARN 3
`define PMICIS_P_OVP 4
`define PMICIS_P_UV 5
`define PMICIS_P_BPG 6
`define PMICIS_P_BSC 8
`define PMICIS_P_LPG 10
`define PMICIS_P_LSC 12

`endif

// File: pmicis_sync2.v
/*
 * two flip-flop synchroniser for a vector of independent levels.
 * assumes each bit is a slow level; no word coherence is implied.
 */
`timescale 1ns/1ps
module pmicis_sync2 #(
    parameter W = 16
) (
    // clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // levels
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // pmicis_sync2

// File: pmicis_sc_timer.v
/*
 * short-circuit qualifier: one-cycle pulse once the below-threshold level has
 * stood longer than the limit. assumes a synchronised level input.
 */
`timescale 1ns/1ps
`include "pmicis_regs.vh"
module pmicis_sc_timer #(
    parameter [`PMICIS_SC_CNT_W-1:0] LIMIT = `PMICIS_SC_CYCLES
) (
    // clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // level and qualified event
    input wire low_in,
    output wire fire_out
);
    reg [`PMICIS_SC_CNT_W-1:0] cnt_q;
    reg fired_q;
    wire over;

    // more than the limit: fire in the same cycle the count equals it
    assign over = (cnt_q == LIMIT);

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= {`PMICIS_SC_CNT_W{1'b0}};
            fired_q <= 1'b0;
        end else if (!low_in) begin
            cnt_q <= {`PMICIS_SC_CNT_W{1'b0}};
            fired_q <= 1'b0;
        end else begin
            // saturate so one long fault gives one event only
            if (!over) begin
                cnt_q <= cnt_q + 1'b1;
            end
            if (over) begin
                fired_q <= 1'b1;
            end
        end
    end

    assign fire_out = low_in && over && !fired_q;
endmodule // pmicis_sc_timer

// File: pmicis_top.v
/*
 * latched interrupt status registers of the power management device: top
 * flags, reset flag, per-buck and per-linear-regulator flags, live status and
 * the software reset bit. assumes the serial interface slave presents register
 * accesses on ref_clk_in; analog comparator levels are asynchronous pins.
 */
`timescale 1ns/1ps
`include "pmicis_regs.vh"
module pmicis_top #(
    parameter [`PMICIS_SC_CNT_W-1:0] SC_CYCLES = `PMICIS_SC_CYCLES
) (
    // clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // register port from the serial interface
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_rd_in,
    output wire [7:0] reg_rdata_out,
    // monitored pins, asynchronous levels
    input wire power_ok_output_in,
    input wire sync_clk_present_in,
    input wire thermal_shutdown_in,
    input wire thermal_warning_in,
    input wire input_overvoltage_in,
    input wire analog_supply_low_in,
    input wire [1:0] buck_pg_invalid_in,
    input wire [1:0] buck_short_in,
    input wire [1:0] buck_ilim_in,
    input wire [1:0] linreg_pg_invalid_in,
    input wire [1:0] linreg_short_in,
    input wire [1:0] linreg_ilim_in,
    // on-clock event from the current measurement logic
    input wire current_measure_done_in,
    // regulator enables: bits 1:0 bucks, 3:2 linear regulators
    input wire [3:0] reg_enable_req_in,
    output wire [3:0] reg_enable_out,
    // general-purpose outputs
    input wire general_output_a_in,
    input wire general_output_b_in,
    output wire general_output_a_out,
    output wire general_output_b_out,
    // reset side effects and summary
    output wire software_reset_out,
    output wire linreg_summary_flag_out
);
    localparam [7:0] ZERO8 = 8'h00;

    // write-one-clear with set priority
    function [7:0] w1c;
        input [7:0] cur;
        input [7:0] clr;
        input [7:0] set;
        input [7:0] mask;
        begin
            w1c = ((cur & ~clr) | set) & mask;
        end
    endfunction

    // write strobe decode for one register
    function [7:0] wclr;
        input wr;
        input [7:0] addr;
        input [7:0] target;
        input [7:0] data;
        begin
            if (wr && (addr == target)) begin
                wclr = data;
            end else begin
                wclr = ZERO8;
            end
        end
    endfunction

    wire [`PMICIS_SYN_W-1:0] pins_raw;
    wire [`PMICIS_SYN_W-1:0] pins_s;
    reg [`PMICIS_SYN_W-1:0] prev_q;
    wire [`PMICIS_SYN_W-1:0] rise;
    wire [`PMICIS_SYN_W-1:0] fall;
    wire [1:0] buck_sc_fire;
    wire [1:0] linreg_sc_fire;

    reg [7:0] top1_q;
    reg [7:0] top1_d;
    reg [7:0] top2_q;
    reg [7:0] top2_d;
    reg [7:0] buck_q;
    reg [7:0] buck_d;
    reg [7:0] linreg_q;
    reg [7:0] linreg_d;
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;
    reg [3:0] en_q;
    reg [3:0] en_d;
    reg [3:0] req_prev_q;
    reg gpo_a_q;
    reg gpo_b_q;
    reg force_low_q;
    reg force_low_d;
    reg swrst_q;

    reg [7:0] top1_set;
    reg [7:0] buck_set;
    reg [7:0] linreg_set;
    wire software_reset_request_req;
    wire restart;
    wire trip;
    wire tsd_block;
    wire [7:0] top1_view;
    wire [7:0] stat_view;

    assign pins_raw = {
        linreg_short_in,
        linreg_pg_invalid_in,
        buck_short_in,
        buck_pg_invalid_in,
        analog_supply_low_in,
        input_overvoltage_in,
        thermal_warning_in,
        thermal_shutdown_in,
        sync_clk_present_in,
        power_ok_output_in
    };

    pmicis_sync2 #(
        .W(`PMICIS_SYN_W)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // current limit levels are sampled straight into flags, so sync them too
    wire [3:0] ilim_s;
    pmicis_sync2 #(
        .W(4)
    ) u_sync_ilim (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .async_in({linreg_ilim_in, buck_ilim_in}),
        .sync_out(ilim_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sc
            pmicis_sc_timer #(
                .LIMIT(SC_CYCLES)
            ) u_buck_sc (
                .ref_clk_in(ref_clk_in),
                .rstn_in(rstn_in),
                .low_in(pins_s[`PMICIS_P_BSC + gi]),
                .fire_out(buck_sc_fire[gi])
            );
            pmicis_sc_timer #(
                .LIMIT(SC_CYCLES)
            ) u_linreg_sc (
                .ref_clk_in(ref_clk_in),
                .rstn_in(rstn_in),
                .low_in(pins_s[`PMICIS_P_LSC + gi]),
                .fire_out(linreg_sc_fire[gi])
            );
        end
    endgenerate

    // edge detection works on the second synchroniser stage only
    assign rise = pins_s & ~prev_q;
    assign fall = ~pins_s & prev_q;

    assign software_reset_request_req = reg_wr_in && (reg_addr_in == `PMICIS_ADDR_RESET)
        && reg_wdata_in[`PMICIS_RST_SW];
    assign restart = rise[`PMICIS_P_UV] || software_reset_request_req;
    assign trip = rise[`PMICIS_P_TSD] || rise[`PMICIS_P_OVP];
    assign tsd_block = top1_q[`PMICIS_T1_TSD];

    // event sources per register
    always @* begin
        top1_set = ZERO8;
        top1_set[`PMICIS_T1_PG_LOST] = fall[`PMICIS_P_PG];
        top1_set[`PMICIS_T1_SYNC] = rise[`PMICIS_P_SYNC] | fall[`PMICIS_P_SYNC];
        top1_set[`PMICIS_T1_TSD] = rise[`PMICIS_P_TSD];
        top1_set[`PMICIS_T1_TWARN] = rise[`PMICIS_P_TWARN];
        top1_set[`PMICIS_T1_OVP] = rise[`PMICIS_P_OVP];
        top1_set[`PMICIS_T1_MEAS] = current_measure_done_in;

        buck_set = ZERO8;
        buck_set[`PMICIS_U_PG_B] = rise[`PMICIS_P_BPG + 1];
        buck_set[`PMICIS_U_PG_A] = rise[`PMICIS_P_BPG];
        buck_set[`PMICIS_U_SC_B] = buck_sc_fire[1];
        buck_set[`PMICIS_U_SC_A] = buck_sc_fire[0];
        buck_set[`PMICIS_U_ILIM_B] = ilim_s[1];
        buck_set[`PMICIS_U_ILIM_A] = ilim_s[0];

        linreg_set = ZERO8;
        linreg_set[`PMICIS_U_PG_B] = rise[`PMICIS_P_LPG + 1];
        linreg_set[`PMICIS_U_PG_A] = rise[`PMICIS_P_LPG];
        linreg_set[`PMICIS_U_SC_B] = linreg_sc_fire[1];
        linreg_set[`PMICIS_U_SC_A] = linreg_sc_fire[0];
        linreg_set[`PMICIS_U_ILIM_B] = ilim_s[3];
        linreg_set[`PMICIS_U_ILIM_A] = ilim_s[2];
    end

    // flag next values: set beats clear, restart returns defaults
    always @* begin
        top1_d = w1c(top1_q, wclr(reg_wr_in, reg_addr_in, `PMICIS_ADDR_TOP1, reg_wdata_in),
            top1_set, `PMICIS_T1_W1C_MASK);
        buck_d = w1c(buck_q, wclr(reg_wr_in, reg_addr_in, `PMICIS_ADDR_BUCK, reg_wdata_in),
            buck_set, `PMICIS_U_W1C_MASK);
        linreg_d = w1c(linreg_q, wclr(reg_wr_in, reg_addr_in, `PMICIS_ADDR_LINREG, reg_wdata_in),
            linreg_set, `PMICIS_U_W1C_MASK);
        top2_d = w1c(top2_q, wclr(reg_wr_in, reg_addr_in, `PMICIS_ADDR_TOP2, reg_wdata_in),
            ZERO8, `PMICIS_T2_W1C_MASK);
        if (restart) begin
            // register defaults come back; only the reset flag is set
            top1_d = `PMICIS_FLAGS_RESET;
            buck_d = `PMICIS_FLAGS_RESET;
            linreg_d = `PMICIS_FLAGS_RESET;
            top2_d = `PMICIS_FLAGS_RESET;
            top2_d[`PMICIS_T2_RST] = 1'b1;
        end
    end

    // regulator enables: dropped by a trip or restart, refused under shutdown
    always @* begin
        en_d = en_q & reg_enable_req_in;
        if (!tsd_block) begin
            en_d = en_d | (reg_enable_req_in & ~req_prev_q);
        end
        if (trip || restart || top1_set[`PMICIS_T1_TSD]) begin
            en_d = 4'h0;
        end
    end

    // outputs held low after a trip until both trip flags are cleared
    always @* begin
        force_low_d = force_low_q;
        if (!top1_d[`PMICIS_T1_TSD] && !top1_d[`PMICIS_T1_OVP]) begin
            force_low_d = 1'b0;
        end
        if (trip) begin
            force_low_d = 1'b1;
        end
        if (restart) begin
            force_low_d = 1'b0;
        end
    end

    assign top1_view = {
        top1_q[`PMICIS_T1_PG_LOST],
        |linreg_q,
        |buck_q,
        top1_q[`PMICIS_T1_SYNC:0]
    };

    assign stat_view = {
        pins_s[`PMICIS_P_PG],
        2'b00,
        ~pins_s[`PMICIS_P_SYNC],
        pins_s[`PMICIS_P_TSD],
        pins_s[`PMICIS_P_TWARN],
        pins_s[`PMICIS_P_OVP],
        1'b0
    };

    // read data, registered on the read strobe; unmapped reads give zero
    always @* begin
        rdata_d = rdata_q;
        if (reg_rd_in) begin
            if (reg_addr_in == `PMICIS_ADDR_TOP1) begin
                rdata_d = top1_view;
            end else if (reg_addr_in == `PMICIS_ADDR_TOP2) begin
                rdata_d = top2_q;
            end else if (reg_addr_in == `PMICIS_ADDR_BUCK) begin
                rdata_d = buck_q;
            end else if (reg_addr_in == `PMICIS_ADDR_LINREG) begin
                rdata_d = linreg_q;
            end else if (reg_addr_in == `PMICIS_ADDR_STAT) begin
                rdata_d = stat_view;
            end else begin
                // the reset bit self clears, so the reset register reads zero
                rdata_d = ZERO8;
            end
        end
    end

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prev_q <= {`PMICIS_SYN_W{1'b0}};
            top1_q <= `PMICIS_FLAGS_RESET;
            top2_q <= `PMICIS_FLAGS_RESET;
            buck_q <= `PMICIS_FLAGS_RESET;
            linreg_q <= `PMICIS_FLAGS_RESET;
            rdata_q <= ZERO8;
            en_q <= 4'h0;
            req_prev_q <= 4'h0;
            gpo_a_q <= 1'b0;
            gpo_b_q <= 1'b0;
            force_low_q <= 1'b0;
            swrst_q <= 1'b0;
        end else begin
            prev_q <= pins_s;
            top1_q <= top1_d;
            top2_q <= top2_d;
            buck_q <= buck_d;
            linreg_q <= linreg_d;
            rdata_q <= rdata_d;
            en_q <= en_d;
            // a refused request must be raised again once the flag clears
            req_prev_q <= reg_enable_req_in;
            force_low_q <= force_low_d;
            gpo_a_q <= general_output_a_in & ~force_low_d;
            gpo_b_q <= general_output_b_in & ~force_low_d;
            swrst_q <= software_reset_request_req;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_enable_out = en_q;
    assign general_output_a_out = gpo_a_q;
    assign general_output_b_out = gpo_b_q;
    assign software_reset_out = swrst_q;
    assign linreg_summary_flag_out = |linreg_q;
endmodule // pmicis_top

// File: pmicis_checker.sv
/*
 * concurrent checks on the ports of pmicis_top.
 * assumes one clock domain and the registered read port of the design.
 */
`timescale 1ns/1ps
module pmicis_checker (
    // clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    // regulator and output side
    input wire [3:0] reg_enable_out,
    input wire general_output_a_out,
    input wire general_output_b_out,
    input wire software_reset_out,
    input wire linreg_summary_flag_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    wire swr = reg_wr_in && reg_addr_in == 8'h18 && reg_wdata_in[0];
    wire rd19 = reg_rd_in && reg_addr_in == 8'h19;

    AST_SWRST_PULSE: assert property (swr |=> software_reset_out)
        else $error("software reset pulse missing");
    AST_SWRST_CAUSE: assert property (software_reset_out |-> $past(swr))
        else $error("software reset pulse without a request");
    AST_RST_ENA: assert property (software_reset_out |-> reg_enable_out == 4'h0)
        else $error("enables kept through restart");
    AST_UNMAPPED: assert property (reg_rd_in && (reg_addr_in < 8'h18 || reg_addr_in > 8'h1D) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    AST_RSV_TOP2: assert property (reg_rd_in && reg_addr_in == 8'h1A |=> reg_rdata_out[7:1] == 7'h00)
        else $error("reserved top two bits set");
    AST_RSV_BUCK: assert property (reg_rd_in && reg_addr_in == 8'h1B |=> (reg_rdata_out & 8'h88) == 8'h00)
        else $error("reserved buck bits set");
    AST_LSUM_LIN: assert property (reg_rd_in && reg_addr_in == 8'h1C |=> (|reg_rdata_out) == $past(linreg_summary_flag_out))
        else $error("linreg summary differs from its flags");
    AST_LSUM_TOP: assert property (rd19 |=> reg_rdata_out[6] == $past(linreg_summary_flag_out))
        else $error("top bit 6 differs from linreg summary");
    AST_TSD_OFF: assert property (rd19 ##1 reg_rdata_out[3] |-> ##2 reg_enable_out == 4'h0 && !general_output_a_out && !general_output_b_out)
        else $error("outputs live while shutdown flag set");
    AST_OVP_OFF: assert property (rd19 ##1 reg_rdata_out[1] |-> ##2 reg_enable_out == 4'h0 && !general_output_a_out)
        else $error("outputs live while overvoltage flag set");
endmodule // pmicis_checker

bind pmicis_top pmicis_checker pmicis_checker_i (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_enable_out(reg_enable_out),
    .general_output_a_out(general_output_a_out), .general_output_b_out(general_output_b_out),
    .software_reset_out(software_reset_out), .linreg_summary_flag_out(linreg_summary_flag_out)
);

// File: pmicis_host.sv
/*
 * host model: single byte reads and writes on the register port.
 * assumes a strobe is taken at the rising edge where it is seen high.
 */
`timescale 1ns/1ps
module pmicis_host (
    // clock
    input wire ref_clk_in,
    // register port
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_rd_out,
    input wire [7:0] reg_rdata_in
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
    end
    // released lines flip so a stale address or byte never looks valid
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        @(posedge ref_clk_in);
        d = reg_rdata_in;
    endtask
endmodule // pmicis_host

// File: pmicis_top_tb.sv
/*
 * self-checking bench for pmicis_top: pins and host accesses in sequence.
 * assumes the short-circuit count is shortened to 20 cycles.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module pmicis_top_tb;
    logic ref_clk_in = 0, rstn_in = 0, pok = 0, syn = 0, tsd = 0, tw = 0, ovp = 0, asl = 0, meas = 0, ga = 0, gb = 0;
    logic [1:0] bpg = 0, bsc = 0, bil = 0, lpg = 0, lsc = 0, lil = 0;
    logic [3:0] req = 0;
    wire [7:0] addr, wdata, rdata;
    wire wr, rd, ga_o, gb_o, swr_o, lsum;
    wire [3:0] en;
    int errors = 0, n_compared = 0;
    always #2.5 ref_clk_in = ~ref_clk_in;

    pmicis_host host_i (.ref_clk_in(ref_clk_in), .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata),
        .reg_rd_out(rd), .reg_rdata_in(rdata));
    pmicis_top #(.SC_CYCLES(18'd20)) pmicis_top_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .power_ok_output_in(pok), .sync_clk_present_in(syn), .thermal_shutdown_in(tsd),
        .thermal_warning_in(tw), .input_overvoltage_in(ovp), .analog_supply_low_in(asl),
        .buck_pg_invalid_in(bpg), .buck_short_in(bsc), .buck_ilim_in(bil), .linreg_pg_invalid_in(lpg),
        .linreg_short_in(lsc), .linreg_ilim_in(lil), .current_measure_done_in(meas),
        .reg_enable_req_in(req), .reg_enable_out(en), .general_output_a_in(ga), .general_output_b_in(gb),
        .general_output_a_out(ga_o), .general_output_b_out(gb_o), .software_reset_out(swr_o),
        .linreg_summary_flag_out(lsum));

    task automatic end_sim;
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host_i.rd_reg(a, v);
        `CHK($sformatf("reg %h", a), e, v)
    endtask
    // a current-limit pin must already be back low, its level still high would win over the clear
    task automatic flag(input logic [7:0] a, input logic [7:0] e);
        wt(6);
        rd_chk(a, e);
        host_i.wr_reg(a, e);
        rd_chk(a, 8'h00);
    endtask

    initial begin
        wt(3);
        rstn_in <= 1;
        wt(2);
        rd_chk(8'h19, 8'h00);
        rd_chk(8'h1A, 8'h00);
        rd_chk(8'h1B, 8'h00);
        rd_chk(8'h20, 8'h00);
        pok <= 1;
        wt(6);
        rd_chk(8'h19, 8'h00);
        rd_chk(8'h1D, 8'h90);
        pok <= 0;
        wt(6);
        rd_chk(8'h19, 8'h80);
        host_i.wr_reg(8'h19, 8'h7F);
        rd_chk(8'h19, 8'h80);
        host_i.wr_reg(8'h19, 8'h80);
        rd_chk(8'h19, 8'h00);
        syn <= 1;
        flag(8'h19, 8'h10);
        rd_chk(8'h1D, 8'h00);
        syn <= 0;
        flag(8'h19, 8'h10);
        tw <= 1;
        flag(8'h19, 8'h04);
        rd_chk(8'h1D, 8'h14);
        tw <= 0;
        wt(6);
        rd_chk(8'h1D, 8'h10);
        meas <= 1;
        wt(1);
        meas <= 0;
        flag(8'h19, 8'h01);
        req <= 4'hF;
        ga <= 1;
        gb <= 1;
        wt(3);
        `CHK("enable", 4'hF, en)
        tsd <= 1;
        wt(6);
        `CHK("enable", 4'h0, en)
        `CHK("outputs", 2'b00, {ga_o, gb_o})
        rd_chk(8'h19, 8'h08);
        req <= 4'h0;
        wt(2);
        req <= 4'hF;
        wt(3);
        `CHK("enable", 4'h0, en)
        host_i.wr_reg(8'h19, 8'h08);
        rd_chk(8'h19, 8'h00);
        rd_chk(8'h1D, 8'h18);
        tsd <= 0;
        req <= 4'h0;
        wt(2);
        req <= 4'hF;
        wt(3);
        `CHK("enable", 4'hF, en)
        `CHK("outputs", 2'b11, {ga_o, gb_o})
        ovp <= 1;
        wt(6);
        `CHK("enable", 4'h0, en)
        `CHK("outputs", 2'b00, {ga_o, gb_o})
        rd_chk(8'h1D, 8'h12);
        ovp <= 0;
        flag(8'h19, 8'h02);
        bil <= 2'b01;
        wt(2);
        bil <= 0;
        wt(6);
        rd_chk(8'h19, 8'h20);
        flag(8'h1B, 8'h01);
        rd_chk(8'h19, 8'h00);
        bil <= 2'b10;
        bpg <= 2'b11;
        wt(2);
        bil <= 0;
        flag(8'h1B, 8'h54);
        bpg <= 0;
        bsc <= 2'b11;
        wt(12);
        rd_chk(8'h1B, 8'h00);
        wt(20);
        bsc <= 0;
        flag(8'h1B, 8'h22);
        bil <= 2'b01;
        wt(6);
        host_i.wr_reg(8'h1B, 8'h01);
        rd_chk(8'h1B, 8'h01);
        bil <= 0;
        flag(8'h1B, 8'h01);
        lpg <= 2'b11;
        lsc <= 2'b11;
        lil <= 2'b11;
        wt(30);
        {lpg, lsc, lil} <= 6'h00;
        wt(6);
        `CHK("linreg summary", 1'b1, lsum)
        rd_chk(8'h19, 8'h40);
        flag(8'h1C, 8'h77);
        `CHK("linreg summary", 1'b0, lsum)
        rd_chk(8'h19, 8'h00);
        // a fresh request edge so the restart has live enables to drop
        meas <= 1;
        req <= 4'h0;
        wt(1);
        meas <= 0;
        req <= 4'hF;
        wt(6);
        `CHK("enable", 4'hF, en)
        host_i.wr_reg(8'h18, 8'h01);
        rd_chk(8'h1A, 8'h01);
        rd_chk(8'h19, 8'h00);
        rd_chk(8'h18, 8'h00);
        `CHK("enable", 4'h0, en)
        host_i.wr_reg(8'h1A, 8'h01);
        rd_chk(8'h1A, 8'h00);
        asl <= 1;
        wt(6);
        rd_chk(8'h1A, 8'h01);
        asl <= 0;
        end_sim();
    end
    initial begin
        wt(20000);
        errors++;
        end_sim();
    end
endmodule // pmicis_top_tb
